/* File: design/fpfl_defs.svh */
// Constants of the FIFO flag logic: widths, defaults, register map.
// Assumes one 25 MHz clock; included by the package and every module.
// How it works
// - Load and enable A pick offset, word, nothing
// - Offsets read back in rotating order
// - Almost flags from offset and pointer gap
// - Empty offset joins low and high parts
// - Almost-empty low at n or fewer words
// - Almost-empty high at n plus one words
// - Full offset joins low and high parts
// - Almost-full low at depth minus m words
// - Almost-full high when free exceeds m
// - All four flags follow the fill table
// - Both offsets default to seven
// - Level at reset picks enable-B or load
// - Data outputs low, floated when disabled
// - Ticks may run during reset
// - Full may lag a just-late write tick
// - Empty may lag a just-late read tick
// - Almost-full may lag a late write tick
// - Almost-empty may lag a late read tick
// - Offset writes rotate through four registers
// - Offset selection survives load release
// - Reset loads defaults and sets flag levels
`ifndef FPFL_DEFS_SVH
`define FPFL_DEFS_SVH

`define FPFL_DW        9
`define FPFL_AW        9
`define FPFL_PW        10
`define FPFL_DEPTH     10'h200
`define FPFL_OFS_W     9
`define FPFL_LO_W      8
`define FPFL_DEF_OFS   9'h007
`define FPFL_ZERO_PTR  10'h000
`define FPFL_ZERO_DAT  9'h000

// Word indices on the bus, byte address is four times the index
`define FPFL_IDX_EOFS  6'h00
`define FPFL_IDX_FOFS  6'h01
`define FPFL_IDX_STAT  6'h02

// Status word fields
`define FPFL_ST_MODE   4
`define FPFL_ST_CNT    16

`endif

/* File: design/fpfl_pkg.sv */
// Types shared by the FIFO flag logic and its bus slave.
// Assumes fpfl_defs.svh is on the include path.
`include "fpfl_defs.svh"

package fpfl_pkg;

	// Flag outputs, all active low
	typedef struct packed {
		logic full_n;
		logic afull_n;
		logic aempty_n;
		logic empty_n;
	} fpfl_flags_s;

	// Offset register rotation
	typedef enum logic [3:0] {
		FPFL_SEL_ELO = 4'h1,
		FPFL_SEL_EHI = 4'h2,
		FPFL_SEL_FLO = 4'h4,
		FPFL_SEL_FHI = 4'h8
	} fpfl_sel_e;

	// Bus slave state
	typedef enum logic [1:0] {
		FPFL_WB_IDLE = 2'h1,
		FPFL_WB_ACK  = 2'h2
	} fpfl_wb_e;

	// Offset update from software, one-cycle strobe
	typedef struct packed {
		logic                     eofs_we;
		logic                     fofs_we;
		logic [1:0]               be;
		logic [`FPFL_OFS_W-1:0]   data;
	} fpfl_cfg_wr_s;

	// Next offset register in the rotation
	function automatic fpfl_sel_e fpfl_next_sel(input fpfl_sel_e s);
		case (s)
			FPFL_SEL_ELO: fpfl_next_sel = FPFL_SEL_EHI;
			FPFL_SEL_EHI: fpfl_next_sel = FPFL_SEL_FLO;
			FPFL_SEL_FLO: fpfl_next_sel = FPFL_SEL_FHI;
			default:      fpfl_next_sel = FPFL_SEL_ELO;
		endcase
	endfunction : fpfl_next_sel

	// Unread words from the two pointers; wrap bit makes full exact
	function automatic logic [`FPFL_PW-1:0] fpfl_fill(
		input logic [`FPFL_PW-1:0] w,
		input logic [`FPFL_PW-1:0] r);
		fpfl_fill = w - r;
	endfunction : fpfl_fill

endpackage : fpfl_pkg

/* File: design/fpfl_ram.sv */
// Storage array of the FIFO, 512 words of 9 bits.
// Assumes writes are gated by the caller; read is combinational.
`include "fpfl_defs.svh"
module fpfl_ram
	import fpfl_pkg::*;
(
	input  wire logic                  clk_i,   // System clock
	input  wire logic                  we_i,    // Store strobe
	input  wire logic [`FPFL_AW-1:0]   waddr_i, // Write address
	input  wire logic [`FPFL_DW-1:0]   wdata_i, // Write data
	input  wire logic [`FPFL_AW-1:0]   raddr_i, // Read address
	output logic      [`FPFL_DW-1:0]   rdata_o  // Read data
);

	logic [`FPFL_DW-1:0] mem [0:`FPFL_DEPTH-1];

	// No reset on the array; contents are undefined until written
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// Caller registers the word into its output stage
	assign rdata_o = mem[raddr_i];

endmodule : fpfl_ram

/* File: design/fpfl_wb.sv */
// Classic Wishbone slave for the offset and status registers.
// Assumes a single-cycle master; answers every access after one cycle.
`include "fpfl_defs.svh"
module fpfl_wb
	import fpfl_pkg::*;
(
	input  wire logic                clk_i,    // System clock
	input  wire logic                rst_i,    // Sync reset, high
	input  wire logic                cyc_i,    // Bus cycle
	input  wire logic                stb_i,    // Strobe
	input  wire logic                we_i,     // Write
	input  wire logic [7:0]          adr_i,    // Byte address
	input  wire logic [3:0]          sel_i,    // Byte enables
	input  wire logic [31:0]         dat_i,    // Write data
	input  wire logic [31:0]         stat_i,   // Status word
	input  wire logic [31:0]         eofs_i,   // Empty offset view
	input  wire logic [31:0]         fofs_i,   // Full offset view
	output logic                     ack_o,    // Acknowledge
	output logic      [31:0]         dat_o,    // Read data
	output fpfl_cfg_wr_s             cfg_wr_o  // Offset write strobe
);

	fpfl_wb_e    state_r;
	logic [5:0]  idx;
	logic        req;

	assign idx = adr_i[7:2];
	assign req = cyc_i & stb_i & (state_r == FPFL_WB_IDLE);

	// Two-state handshake so ack drops the cycle after it is given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= FPFL_WB_IDLE;
		end else begin
			case (state_r)
				FPFL_WB_IDLE: if (req) state_r <= FPFL_WB_ACK;
				FPFL_WB_ACK:  state_r <= FPFL_WB_IDLE;
				default:      state_r <= FPFL_WB_IDLE;
			endcase
		end
	end

	// Answer and read data; unmapped words read zero, writes dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= req;
			if (req && !we_i) begin
				case (idx)
					`FPFL_IDX_EOFS: dat_o <= eofs_i;
					`FPFL_IDX_FOFS: dat_o <= fofs_i;
					`FPFL_IDX_STAT: dat_o <= stat_i;
					default:        dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	// Strobe rides with ack, so the store lands on the master's edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_wr_o <= '0;
		end else begin
			cfg_wr_o.eofs_we <= req & we_i & (idx == `FPFL_IDX_EOFS);
			cfg_wr_o.fofs_we <= req & we_i & (idx == `FPFL_IDX_FOFS);
			cfg_wr_o.be      <= sel_i[1:0];
			cfg_wr_o.data    <= dat_i[`FPFL_OFS_W-1:0];
		end
	end

endmodule : fpfl_wb

/* File: design/fpfl_top.sv */
// FIFO with empty, full and programmable almost flags, 512 x 9.
// Assumes write and read ports are same-clock logic that marks each
// port clock edge with a one-cycle tick; software on classic Wishbone.
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`include "fpfl_defs.svh"
module fpfl_top
	import fpfl_pkg::*;
(
	input  wire logic                clk_i,                  // 25 MHz
	input  wire logic                rst_i,                  // Sync, high
	input  wire logic                wb_cyc_i,               // Bus cycle
	input  wire logic                wb_stb_i,               // Strobe
	input  wire logic                wb_we_i,                // Write
	input  wire logic [7:0]          wb_adr_i,               // Address
	input  wire logic [3:0]          wb_sel_i,               // Byte lanes
	input  wire logic [31:0]         wb_dat_i,               // Write data
	output logic      [31:0]         wb_dat_o,               // Read data
	output logic                     wb_ack_o,               // Acknowledge
	input  wire logic                wr_tick_i,              // Write edge
	input  wire logic                rd_tick_i,              // Read edge
	input  wire logic [`FPFL_DW-1:0] data_in_i,              // Write word
	input  wire logic                write_enable_a_n_i,     // Enable A
	input  wire logic                write_enable_b_or_load_i, // B or load
	input  wire logic                read_enable_a_n_i,      // Read en A
	input  wire logic                read_enable_b_n_i,      // Read en B
	input  wire logic                output_enable_n_i,      // Out enable
	output logic      [`FPFL_DW-1:0] data_out_bus_o,         // Read word
	output logic                     data_out_oe_o,          // Drive bus
	output logic                     empty_flag_n_o,         // Empty
	output logic                     full_flag_n_o,          // Full
	output logic                     almost_empty_flag_n_o,  // Almost empty
	output logic                     almost_full_flag_n_o    // Almost full
);

	// Default offset as a typed constant, so its halves can be selected
	localparam logic [`FPFL_OFS_W-1:0] DEF_OFS = `FPFL_DEF_OFS;

	logic                    load_mode_r;  // Pin acts as load enable
	fpfl_sel_e               wsel_r;
	fpfl_sel_e               rsel_r;
	logic [`FPFL_LO_W-1:0]   elo_r;
	logic [`FPFL_LO_W-1:0]   flo_r;
	logic                    ehi_r;
	logic                    fhi_r;
	logic [`FPFL_PW-1:0]     wptr_r;
	logic [`FPFL_PW-1:0]     rptr_r;
	logic [`FPFL_PW-1:0]     wptr_nxt;
	logic [`FPFL_PW-1:0]     rptr_nxt;
	fpfl_flags_s             flags_r;
	logic [`FPFL_DW-1:0]     q_r;
	logic [`FPFL_DW-1:0]     ram_q;
	logic [`FPFL_OFS_W-1:0]  n_ofs;
	logic [`FPFL_OFS_W-1:0]  m_ofs;
	logic [`FPFL_PW-1:0]     wfill;
	logic [`FPFL_PW-1:0]     rfill;
	logic                    offset_load_n;
	logic                    ofs_wr;
	logic                    ofs_rd;
	logic                    fifo_wr;
	logic                    fifo_rd;
	logic                    run;
	fpfl_cfg_wr_s            cfg_wr;
	logic [31:0]             stat_word;

	// Ticks seen while reset is held are simply ignored
	assign run = ~rst_i;

	// Shared pin only means load once the strap chose that role
	assign offset_load_n = ~load_mode_r | write_enable_b_or_load_i;

	// Action decode on a write tick
	assign ofs_wr  = run & wr_tick_i & load_mode_r
	               & ~write_enable_b_or_load_i
	               & ~write_enable_a_n_i;
	assign fifo_wr = run & wr_tick_i & ~write_enable_a_n_i
	               & write_enable_b_or_load_i
	               & flags_r.full_n;

	// Action decode on a read tick; load gates ordinary reads
	assign ofs_rd  = run & rd_tick_i & load_mode_r
	               & ~write_enable_b_or_load_i
	               & ~read_enable_a_n_i & ~read_enable_b_n_i;
	assign fifo_rd = run & rd_tick_i & offset_load_n
	               & ~read_enable_a_n_i & ~read_enable_b_n_i
	               & flags_r.empty_n;

	// Offsets are whole numbers built from their two halves
	assign n_ofs = {ehi_r, elo_r};
	assign m_ofs = {fhi_r, flo_r};

	// Offset traffic never touches the pointers
	assign wptr_nxt = fifo_wr ? wptr_r + 10'h001 : wptr_r;
	assign rptr_nxt = fifo_rd ? rptr_r + 10'h001 : rptr_r;

	// Each side sees its own move but not the far side's same-cycle one
	assign wfill = fpfl_fill(wptr_nxt, rptr_r);
	assign rfill = fpfl_fill(wptr_r, rptr_nxt);

	// Strap caught on every reset cycle, the last one before release wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			load_mode_r <= ~write_enable_b_or_load_i;
		end
	end

	// Offset write rotation, kept across load release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wsel_r <= FPFL_SEL_ELO;
		end else if (ofs_wr) begin
			wsel_r <= fpfl_next_sel(wsel_r);
		end
	end

	// Offset read rotation, same order as writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rsel_r <= FPFL_SEL_ELO;
		end else if (ofs_rd) begin
			rsel_r <= fpfl_next_sel(rsel_r);
		end
	end

	// Offset registers: pin writes beat a software write in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			elo_r <= DEF_OFS[`FPFL_LO_W-1:0];
			ehi_r <= DEF_OFS[`FPFL_LO_W];
			flo_r <= DEF_OFS[`FPFL_LO_W-1:0];
			fhi_r <= DEF_OFS[`FPFL_LO_W];
		end else if (ofs_wr) begin
			case (wsel_r)
				FPFL_SEL_ELO: elo_r <= data_in_i[`FPFL_LO_W-1:0];
				FPFL_SEL_EHI: ehi_r <= data_in_i[0];
				FPFL_SEL_FLO: flo_r <= data_in_i[`FPFL_LO_W-1:0];
				FPFL_SEL_FHI: fhi_r <= data_in_i[0];
				default:      elo_r <= elo_r;
			endcase
		end else begin
			if (cfg_wr.eofs_we && cfg_wr.be[0])
				elo_r <= cfg_wr.data[`FPFL_LO_W-1:0];
			if (cfg_wr.eofs_we && cfg_wr.be[1])
				ehi_r <= cfg_wr.data[`FPFL_LO_W];
			if (cfg_wr.fofs_we && cfg_wr.be[0])
				flo_r <= cfg_wr.data[`FPFL_LO_W-1:0];
			if (cfg_wr.fofs_we && cfg_wr.be[1])
				fhi_r <= cfg_wr.data[`FPFL_LO_W];
		end
	end

	// Write pointer moves only on a real word store
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wptr_r <= `FPFL_ZERO_PTR;
		end else begin
			wptr_r <= wptr_nxt;
		end
	end

	// Read pointer moves only on a real word fetch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rptr_r <= `FPFL_ZERO_PTR;
		end else begin
			rptr_r <= rptr_nxt;
		end
	end

	// Write-side flags, one flop each, updated on write ticks only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_r.full_n  <= 1'b1;
			flags_r.afull_n <= 1'b1;
		end else if (run && wr_tick_i) begin
			flags_r.full_n  <= (wfill != `FPFL_DEPTH);
			// Low once fill plus m reaches depth, high when free > m
			flags_r.afull_n <= ({1'b0, wfill} + {2'b00, m_ofs})
			                 < {1'b0, `FPFL_DEPTH};
		end
	end

	// Read-side flags, one flop each, updated on read ticks only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_r.empty_n  <= 1'b0;
			flags_r.aempty_n <= 1'b0;
		end else if (run && rd_tick_i) begin
			flags_r.empty_n  <= (rfill != `FPFL_ZERO_PTR);
			// Low at n or fewer unread words, high from n plus one
			flags_r.aempty_n <= rfill > {1'b0, n_ofs};
		end
	end

	// Output word register; an offset read shows the selected half
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_r <= `FPFL_ZERO_DAT;
		end else if (ofs_rd) begin
			case (rsel_r)
				FPFL_SEL_ELO: q_r <= {1'b0, elo_r};
				FPFL_SEL_EHI: q_r <= {8'h00, ehi_r};
				FPFL_SEL_FLO: q_r <= {1'b0, flo_r};
				FPFL_SEL_FHI: q_r <= {8'h00, fhi_r};
				default:      q_r <= `FPFL_ZERO_DAT;
			endcase
		end else if (fifo_rd) begin
			q_r <= ram_q;
		end
	end

	// Enable is registered so the bus driver comes from a flop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_out_oe_o <= 1'b0;
		end else begin
			data_out_oe_o <= ~output_enable_n_i;
		end
	end

	assign data_out_bus_o        = q_r;
	assign empty_flag_n_o        = flags_r.empty_n;
	assign full_flag_n_o         = flags_r.full_n;
	assign almost_empty_flag_n_o = flags_r.aempty_n;
	assign almost_full_flag_n_o  = flags_r.afull_n;

	// Status word for software
	always_comb begin
		stat_word = 32'h00000000;
		stat_word[3:0] = flags_r;
		stat_word[`FPFL_ST_MODE] = load_mode_r;
		stat_word[`FPFL_ST_CNT +: `FPFL_PW] = fpfl_fill(wptr_r, rptr_r);
	end

	// Word storage
	fpfl_ram u_ram (
		.clk_i   (clk_i),
		.we_i    (fifo_wr),
		.waddr_i (wptr_r[`FPFL_AW-1:0]),
		.wdata_i (data_in_i),
		.raddr_i (rptr_r[`FPFL_AW-1:0]),
		.rdata_o (ram_q)
	);

	// Register access for software
	fpfl_wb u_wb (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.cyc_i    (wb_cyc_i),
		.stb_i    (wb_stb_i),
		.we_i     (wb_we_i),
		.adr_i    (wb_adr_i),
		.sel_i    (wb_sel_i),
		.dat_i    (wb_dat_i),
		.stat_i   (stat_word),
		.eofs_i   ({23'h000000, n_ofs}),
		.fofs_i   ({23'h000000, m_ofs}),
		.ack_o    (wb_ack_o),
		.dat_o    (wb_dat_o),
		.cfg_wr_o (cfg_wr)
	);

endmodule : fpfl_top

/* File: tb/fpfl_top_properties.sv */
// Checker of the flag logic top: flag timing, reset levels, output.
// Assumes a bind to fpfl_top; sees only the top's ports.
`include "fpfl_defs.svh"
module fpfl_top_properties (
	input wire logic                clk_i,                    // Clock
	input wire logic                rst_i,                    // Reset
	input wire logic                wb_ack_o,                 // Ack
	input wire logic                wr_tick_i,                // Write edge
	input wire logic                rd_tick_i,                // Read edge
	input wire logic                write_enable_a_n_i,       // Enable A
	input wire logic                write_enable_b_or_load_i, // B or load
	input wire logic                output_enable_n_i,        // Out enable
	input wire logic [`FPFL_DW-1:0] data_out_bus_o,           // Read word
	input wire logic                data_out_oe_o,            // Drive bus
	input wire logic                empty_flag_n_o,           // Empty
	input wire logic                full_flag_n_o,            // Full
	input wire logic                almost_empty_flag_n_o,    // Almost empty
	input wire logic                almost_full_flag_n_o      // Almost full
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Flags only move on their own port edge, so a late far edge waits
	full_hold_a: assert property (
		!wr_tick_i |=> $stable(full_flag_n_o))
		else $error("full flag moved without a write edge");
	afull_hold_a: assert property (
		!wr_tick_i |-> ##1 $stable(almost_full_flag_n_o))
		else $error("almost full moved without a write edge");
	empty_hold_a: assert property (
		!rd_tick_i |=> $stable(empty_flag_n_o))
		else $error("empty flag moved without a read edge");
	aempty_hold_a: assert property (
		!rd_tick_i |-> ##1 $stable(almost_empty_flag_n_o))
		else $error("almost empty moved without a read edge");
	// Fill table corners: full lies inside almost full, empty likewise
	full_in_afull_a: assert property (
		!full_flag_n_o |-> !almost_full_flag_n_o)
		else $error("full without almost full");
	empty_in_aempty_a: assert property (
		!empty_flag_n_o |-> !almost_empty_flag_n_o)
		else $error("empty without almost empty");
	reset_levels_a: assert property (
		$fell(rst_i) |-> full_flag_n_o && almost_full_flag_n_o &&
		!almost_empty_flag_n_o && !empty_flag_n_o && data_out_bus_o == '0)
		else $error("flag or output levels wrong after reset");
	dout_hold_a: assert property (
		!rd_tick_i |=> $stable(data_out_bus_o))
		else $error("read word moved without a read edge");
	oe_follow_a: assert property (
		!rst_i |=> data_out_oe_o == !$past(output_enable_n_i))
		else $error("output drive does not follow enable");

	cover property (!full_flag_n_o);
	cover property (wr_tick_i && !write_enable_b_or_load_i &&
		!write_enable_a_n_i);
	cover property (wb_ack_o);
endmodule : fpfl_top_properties

bind fpfl_top fpfl_top_properties i_fpfl_top_properties (
	.clk_i(clk_i), .rst_i(rst_i), .wb_ack_o(wb_ack_o),
	.wr_tick_i(wr_tick_i), .rd_tick_i(rd_tick_i),
	.write_enable_a_n_i(write_enable_a_n_i),
	.write_enable_b_or_load_i(write_enable_b_or_load_i),
	.output_enable_n_i(output_enable_n_i),
	.data_out_bus_o(data_out_bus_o), .data_out_oe_o(data_out_oe_o),
	.empty_flag_n_o(empty_flag_n_o), .full_flag_n_o(full_flag_n_o),
	.almost_empty_flag_n_o(almost_empty_flag_n_o),
	.almost_full_flag_n_o(almost_full_flag_n_o));

/* File: tb/fpfl_port_model.sv */
// Far-side writer and reader: ticks, enables and write words.
// Assumes one shared clock; each port edge is a one-cycle tick.
`include "fpfl_defs.svh"
module fpfl_port_model (
	input  wire logic               clk_i,     // System clock
	output logic                    wr_tick_o, // Write edge
	output logic                    rd_tick_o, // Read edge
	output logic [`FPFL_DW-1:0]     data_o,    // Write word
	output logic                    wen_a_n_o, // Enable A
	output logic                    ld_o,      // Enable B or load
	output logic [1:0]              ren_n_o,   // Read enables B, A
	output logic                    oe_n_o     // Output enable
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle levels at time zero
	initial begin
		wr_tick_o = 1'b0;
		rd_tick_o = 1'b0;
		data_o    = '0;
		wen_a_n_o = 1'b1;
		ld_o      = 1'b1;
		ren_n_o   = 2'b11;
		oe_n_o    = 1'b0;
	end
	// One write edge; tasks never overlap, so no offset write meets a read
	task automatic wr(input logic ld, input logic en_n,
		input logic [`FPFL_DW-1:0] d);
		@(posedge clk_i);
		wr_tick_o <= 1'b1;
		wen_a_n_o <= en_n;
		ld_o      <= ld;
		data_o    <= d;
		@(posedge clk_i);
		wr_tick_o <= 1'b0;
		wen_a_n_o <= 1'b1;
		data_o    <= ~d; // Released line shows no stale word
		@(negedge clk_i); // Flags launched at the tick edge have settled
	endtask : wr
	// One read edge; load low with both enables low reads an offset
	task automatic rd(input logic ld, input logic [1:0] en_n);
		@(posedge clk_i);
		rd_tick_o <= 1'b1;
		ren_n_o   <= en_n;
		ld_o      <= ld;
		@(posedge clk_i);
		rd_tick_o <= 1'b0;
		ren_n_o   <= 2'b11;
		@(negedge clk_i); // Read word and flags settle before any check
	endtask : rd
	// Level held through reset picks the pin's role
	task automatic set_ld(input logic v);
		ld_o <= v;
	endtask : set_ld
	task automatic set_oe(input logic v);
		oe_n_o <= v;
	endtask : set_oe
endmodule : fpfl_port_model

/* File: tb/tb_top.sv */
// Testbench of the FIFO flag logic: pin and Wishbone sequences.
// Assumes the checker is bound; the port model drives the FIFO side.
`include "fpfl_defs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 clk_i     = 1'b0;
	logic                 rst_i     = 1'b1;
	logic                 wb_cyc_i  = 1'b0;
	logic                 wb_stb_i  = 1'b0;
	logic                 wb_we_i   = 1'b0;
	logic [7:0]           wb_adr_i  = 8'h00;
	logic [3:0]           wb_sel_i  = 4'h3;
	logic [31:0]          wb_dat_i  = 32'h0;
	logic [31:0]          wb_dat_o, rd;
	logic                 wb_ack_o, wr_tick, rd_tick, wen_a_n, ld, oe_n;
	logic [1:0]           ren_n;
	logic [`FPFL_DW-1:0]  din, dout;
	logic                 dout_oe, empty_n, full_n, aempty_n, afull_n;
	int                   error_cnt = 0;
	int                   n_compared = 0;
	int                   cnt = 0;
	int                   cyc_cnt = 0;
	int                   pts_a[7] = '{1, 7, 8, 504, 505, 511, 512};
	int                   pts_b[4] = '{250, 251, 258, 259};
	logic [31:0]          ofs_rd[4] = '{32'h2, 32'h1, 32'h5, 32'h0};

	fpfl_port_model i_fpfl_port_model (.clk_i(clk_i), .wr_tick_o(wr_tick),
		.rd_tick_o(rd_tick), .data_o(din), .wen_a_n_o(wen_a_n), .ld_o(ld),
		.ren_n_o(ren_n), .oe_n_o(oe_n));
	fpfl_top i_fpfl_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .wr_tick_i(wr_tick), .rd_tick_i(rd_tick),
		.data_in_i(din), .write_enable_a_n_i(wen_a_n),
		.write_enable_b_or_load_i(ld), .read_enable_a_n_i(ren_n[0]),
		.read_enable_b_n_i(ren_n[1]), .output_enable_n_i(oe_n),
		.data_out_bus_o(dout), .data_out_oe_o(dout_oe),
		.empty_flag_n_o(empty_n), .full_flag_n_o(full_n),
		.almost_empty_flag_n_o(aempty_n), .almost_full_flag_n_o(afull_n));

	// 25 MHz clock
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	// Hang guard: the whole run needs under two thousand cycles
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 10000) begin
			error_cnt++;
			stop_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask : chk
	// Classic single cycle; waits for ack under a bound
	task automatic wb_xfer(input logic we, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] q);
		int t;
		t = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= wd;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && t < 16) begin
			@(posedge clk_i);
			t++;
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (t == 16) begin
			chk("wb_ack", 32'h1, 32'h0);
		end
	endtask : wb_xfer
	task automatic wb_chk(input logic [7:0] a, input logic [31:0] e);
		wb_xfer(1'b0, a, 32'h0, rd);
		chk("wb_dat", e, rd);
	endtask : wb_chk
	task automatic do_reset(input logic v);
		@(posedge clk_i);
		rst_i <= 1'b1;
		i_fpfl_port_model.set_ld(v);
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		cnt = 0;
	endtask : do_reset
	task automatic push_to(input int t);
		while (cnt < t) begin
			i_fpfl_port_model.wr(1'b1, 1'b0, cnt[8:0]);
			cnt++;
		end
	endtask : push_to
	// Idle edges on both ports let each side see the far pointer
	task automatic check_lvl(input int n, input int m, input logic md);
		logic [3:0] ef;
		i_fpfl_port_model.wr(1'b1, 1'b1, 9'h000);
		i_fpfl_port_model.rd(1'b1, 2'b11);
		ef = {cnt != 512, cnt + m < 512, cnt > n, cnt != 0};
		chk("flags", ef, {full_n, afull_n, aempty_n, empty_n});
		wb_xfer(1'b0, 8'h08, 32'h0, rd);
		chk("status", {md, ef}, rd[4:0]);
		chk("fill", cnt, rd[25:16]);
	endtask : check_lvl
	task automatic stop_test();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test

	initial begin
		do_reset(1'b1);
		check_lvl(7, 7, 1'b0);
		chk("dout", 32'h0, dout);
		chk("oe", 32'h1, dout_oe);
		i_fpfl_port_model.set_oe(1'b1);
		wb_chk(8'h00, 32'h7);
		chk("oe", 32'h0, dout_oe);
		i_fpfl_port_model.set_oe(1'b0);
		wb_chk(8'h04, 32'h7);
		wb_chk(8'h0C, 32'h0);
		foreach (pts_a[i]) begin
			push_to(pts_a[i]);
			check_lvl(7, 7, 1'b0);
		end
		i_fpfl_port_model.wr(1'b1, 1'b0, 9'h1FF); // Refused while full
		check_lvl(7, 7, 1'b0);
		i_fpfl_port_model.rd(1'b1, 2'b00);
		cnt--;
		chk("dout", 32'h0, dout); // First word comes out first
		check_lvl(7, 7, 1'b0);
		// Load mode: offsets through the pins, one release in between
		do_reset(1'b0);
		check_lvl(7, 7, 1'b1);
		i_fpfl_port_model.wr(1'b0, 1'b0, 9'h003);
		i_fpfl_port_model.wr(1'b0, 1'b0, 9'h001);
		i_fpfl_port_model.wr(1'b1, 1'b1, 9'h000);
		i_fpfl_port_model.wr(1'b0, 1'b0, 9'h005);
		i_fpfl_port_model.wr(1'b0, 1'b0, 9'h000);
		i_fpfl_port_model.wr(1'b0, 1'b0, 9'h002);
		wb_chk(8'h00, 32'h102);
		wb_chk(8'h04, 32'h5);
		foreach (ofs_rd[i]) begin
			i_fpfl_port_model.rd(1'b0, 2'b00);
			chk("dout", ofs_rd[i], dout);
		end
		check_lvl(258, 5, 1'b1);
		wb_xfer(1'b1, 8'h04, 32'h105, rd);
		wb_chk(8'h04, 32'h105);
		foreach (pts_b[i]) begin
			push_to(pts_b[i]);
			check_lvl(258, 261, 1'b1);
		end
		stop_test();
	end
endmodule : tb_top
